/* hw/soc_pkg.sv */
// Purpose: Shared constants for the switchgear object control block
// Assumes: 50 MHz system clock
// Notes:   Times are kept in ms and converted to cycles here
package soc_pkg;
	localparam int unsigned CLK_HZ          = 50000000;
	localparam int unsigned CNT_W           = 32;
	localparam int unsigned PULSE_MAX_MS    = 200;
	localparam int unsigned TERM_TOUT_MS    = 10000;
	localparam int unsigned PULSE_MAX_CYC   = PULSE_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned TERM_TOUT_CYC   = TERM_TOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned TMR_W           = 32;

	typedef enum logic [1:0]
	{
		SOC_TYPE_WD_BREAKER  = 2'h0,
		SOC_TYPE_BREAKER     = 2'h1,
		SOC_TYPE_DISC_MAIN   = 2'h2,
		SOC_TYPE_DISC_EARTH  = 2'h3
	} soc_type_t;

	typedef enum logic [1:0]
	{
		SOC_POS_INTERMEDIATE = 2'h0,
		SOC_POS_OPEN         = 2'h1,
		SOC_POS_CLOSED       = 2'h2,
		SOC_POS_BAD          = 2'h3
	} soc_pos_t;

	localparam logic [2:0] SOC_CART_INTERMEDIATE = 3'h0;
	localparam logic [2:0] SOC_CART_OUT          = 3'h1;
	localparam logic [2:0] SOC_CART_IN           = 3'h2;
	localparam logic [2:0] SOC_CART_BAD          = 3'h3;
	localparam logic [2:0] SOC_CART_NOT_USED     = 3'h4;

	localparam logic [1:0] SOC_RDY_HIGH          = 2'h0;
	localparam logic [1:0] SOC_RDY_LOW           = 2'h1;
	localparam logic [1:0] SOC_RDY_NOT_USED      = 2'h2;
	localparam logic       SOC_SYNC_NOT_USED     = 1'b0;
	localparam logic       SOC_SYNC_IN_USE       = 1'b1;

	typedef enum logic [1:0]
	{
		SOC_ST_IDLE  = 2'h0,
		SOC_ST_OPEN  = 2'h1,
		SOC_ST_CLOSE = 2'h2
	} soc_state_t;
endpackage

/* hw/soc_sync2.sv */
// Purpose: Two-flop synchroniser for a bank of pin inputs
// Assumes: Inputs are asynchronous to sys_clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module soc_sync2 #(
	parameter int unsigned WIDTH = 1
)
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			stage1 <= '0;
			sync_o <= '0;
		end
		else
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

/* hw/soc_object_ctrl.sv */
// Purpose: Control and monitoring of one switchgear object
// Assumes: Single 50 MHz clock, synchronous active-low reset, pins are asynchronous
// Notes:   Interlocks arrive as blocking inputs; one request at a time
`timescale 1ns/1ns
module soc_object_ctrl
	import soc_pkg::*;
#(
	parameter int unsigned PULSE_CYC = PULSE_MAX_CYC,
	parameter int unsigned TOUT_CYC  = TERM_TOUT_CYC
)
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [1:0]       object_type_i,
	input  wire logic             sync_use_i,
	input  wire logic [1:0]       ready_use_i,
	input  wire logic             open_pos_i,
	input  wire logic             closed_pos_i,
	input  wire logic             cart_inserted_input_i,
	input  wire logic             cart_removed_input_i,
	input  wire logic             ready_i,
	input  wire logic             sync_ok_i,
	input  wire logic             open_req_i,
	input  wire logic             close_req_i,
	input  wire logic             open_block_i,
	input  wire logic             close_block_i,
	input  wire logic             clear_stats_i,
	output logic                  open_cmd_o,
	output logic                  close_cmd_o,
	output logic [1:0]            breaker_status_o,
	output logic [2:0]            cart_status_o,
	output logic                  busy_o,
	output logic                  clear_stats_o,
	output logic                  ctrl_error_o,
	output logic                  req_refused_o,
	output logic [CNT_W-1:0]      open_ok_cnt_o,
	output logic [CNT_W-1:0]      close_ok_cnt_o,
	output logic [CNT_W-1:0]      open_fail_cnt_o,
	output logic [CNT_W-1:0]      close_fail_cnt_o
);
	localparam logic [TMR_W-1:0] PULSE_LIM = TMR_W'(PULSE_CYC);
	localparam logic [TMR_W-1:0] TOUT_LIM  = TMR_W'(TOUT_CYC);

	logic [5:0]       pins_s;
	logic             open_s;
	logic             closed_s;
	logic             cart_in_s;
	logic             cart_out_s;
	logic             ready_s;
	logic             sync_s;
	soc_type_t        obj_type;
	soc_state_t       state;
	logic [TMR_W-1:0] tmr;
	logic             is_breaker;
	logic             ready_ok;
	logic             sync_ok;
	logic             can_ctrl;
	logic             close_gate_ok;
	logic             take_open;
	logic             take_close;
	logic             refuse_open;
	logic             refuse_close;
	logic             pos_changed;
	logic             timed_out;
	logic             inc_open_ok;
	logic             inc_close_ok;
	logic             inc_open_fail;
	logic             inc_close_fail;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and status decode

	soc_sync2 #(
		.WIDTH (6)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   ({open_pos_i, closed_pos_i, cart_inserted_input_i,
		             cart_removed_input_i, ready_i, sync_ok_i}),
		.sync_o    (pins_s)
	);

	assign open_s     = pins_s[5];
	assign closed_s   = pins_s[4];
	assign cart_in_s  = pins_s[3];
	assign cart_out_s = pins_s[2];
	assign ready_s    = pins_s[1];
	assign sync_s     = pins_s[0];
	assign obj_type   = soc_type_t'(object_type_i);

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			breaker_status_o <= SOC_POS_INTERMEDIATE;
		else
			breaker_status_o <= {closed_s, open_s};
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			cart_status_o <= SOC_CART_NOT_USED;
		else if (obj_type != SOC_TYPE_WD_BREAKER)
			cart_status_o <= SOC_CART_NOT_USED;
		else
			cart_status_o <= {1'b0, cart_in_s, cart_out_s};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request gating

	assign is_breaker = (obj_type == SOC_TYPE_WD_BREAKER) || (obj_type == SOC_TYPE_BREAKER);
	assign can_ctrl   = (obj_type != SOC_TYPE_DISC_EARTH);

	always_comb
	begin
		case (ready_use_i)
			SOC_RDY_HIGH: ready_ok = ready_s;
			SOC_RDY_LOW:  ready_ok = !ready_s;
			default:      ready_ok = 1'b1;
		endcase
	end

	assign sync_ok       = (sync_use_i == SOC_SYNC_NOT_USED) || sync_s;
	// Gating is ignored for disconnectors
	assign close_gate_ok = !is_breaker || (ready_ok && sync_ok);

	// Open wins if both requests come together; the close is dropped silently
	assign take_open    = (state == SOC_ST_IDLE) && can_ctrl && open_req_i && !open_block_i;
	assign take_close   = (state == SOC_ST_IDLE) && can_ctrl && close_req_i && !open_req_i
	                      && !close_block_i && close_gate_ok;
	assign refuse_open  = 1'b0;
	assign refuse_close = (state == SOC_ST_IDLE) && can_ctrl && close_req_i && !open_req_i
	                      && !close_block_i && !close_gate_ok;

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer

	assign pos_changed = (state == SOC_ST_OPEN)  ? (open_s && !closed_s) :
	                     (state == SOC_ST_CLOSE) ? (closed_s && !open_s) : 1'b0;
	assign timed_out   = (state != SOC_ST_IDLE) && !pos_changed && (tmr >= TOUT_LIM - 1'b1);

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			state     <= SOC_ST_IDLE;
			tmr       <= '0;
		end
		else
		begin
			case (state)
				SOC_ST_IDLE:
				begin
					tmr <= '0;
					if (take_open)
						state <= SOC_ST_OPEN;
					else if (take_close)
						state <= SOC_ST_CLOSE;
				end
				SOC_ST_OPEN, SOC_ST_CLOSE:
				begin
					tmr <= tmr + 1'b1;
					if (pos_changed || timed_out)
						state <= SOC_ST_IDLE;
				end
				default:
					state <= SOC_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			open_cmd_o  <= 1'b0;
			close_cmd_o <= 1'b0;
		end
		else
		begin
			// Pulse drops at max length but control stays armed until timeout
			open_cmd_o  <= can_ctrl && (take_open || ((state == SOC_ST_OPEN) && !pos_changed
			               && !timed_out && (tmr < PULSE_LIM - 1'b1)));
			close_cmd_o <= can_ctrl && (take_close || ((state == SOC_ST_CLOSE) && !pos_changed
			               && !timed_out && (tmr < PULSE_LIM - 1'b1)));
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_error_o  <= 1'b0;
			req_refused_o <= 1'b0;
		end
		else
		begin
			ctrl_error_o  <= timed_out;
			req_refused_o <= refuse_open || refuse_close;
		end
	end

	assign busy_o = (state != SOC_ST_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// Statistics

	assign inc_open_ok    = (state == SOC_ST_OPEN)  && pos_changed;
	assign inc_close_ok   = (state == SOC_ST_CLOSE) && pos_changed;
	assign inc_open_fail  = ((state == SOC_ST_OPEN) && timed_out) || refuse_open;
	assign inc_close_fail = ((state == SOC_ST_CLOSE) && timed_out) || refuse_close;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			clear_stats_o <= 1'b0;
		else if (clear_stats_o)
			clear_stats_o <= 1'b0;
		else
			clear_stats_o <= clear_stats_i;
	end

	// Clear takes priority over a same-cycle increment: the whole set restarts
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || clear_stats_o)
		begin
			open_ok_cnt_o    <= '0;
			close_ok_cnt_o   <= '0;
			open_fail_cnt_o  <= '0;
			close_fail_cnt_o <= '0;
		end
		else
		begin
			if (inc_open_ok)
				open_ok_cnt_o <= open_ok_cnt_o + 1'b1;
			if (inc_close_ok)
				close_ok_cnt_o <= close_ok_cnt_o + 1'b1;
			if (inc_open_fail)
				open_fail_cnt_o <= open_fail_cnt_o + 1'b1;
			if (inc_close_fail)
				close_fail_cnt_o <= close_fail_cnt_o + 1'b1;
		end
	end
endmodule

/* verification/soc_object_ctrl_asserts.sv */
// Purpose: Port-level checks of the object control block
// Assumes: Bench holds gating pins steady around each request
// Notes:   Position pins pass a two-flop synchroniser first
`timescale 1ns/1ns
module soc_object_ctrl_chk
	import soc_pkg::*;
#(
	parameter int unsigned PULSE_CYC = 20
)
(
	input wire logic             sys_clk_i,
	input wire logic             rst_n_i,
	input wire logic [1:0]       object_type_i,
	input wire logic             sync_use_i,
	input wire logic [1:0]       ready_use_i,
	input wire logic             open_pos_i,
	input wire logic             closed_pos_i,
	input wire logic             ready_i,
	input wire logic             sync_ok_i,
	input wire logic             clear_stats_i,
	input wire logic             open_cmd_o,
	input wire logic             close_cmd_o,
	input wire logic [1:0]       breaker_status_o,
	input wire logic [2:0]       cart_status_o,
	input wire logic             clear_stats_o,
	input wire logic [CNT_W-1:0] open_ok_cnt_o,
	input wire logic [CNT_W-1:0] close_fail_cnt_o
);
	logic [31:0] hi_cnt;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Relay on-time, so a pulse that never ends is caught
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || !(open_cmd_o || close_cmd_o))
			hi_cnt <= 32'h0;
		else
			hi_cnt <= hi_cnt + 32'h1;
	end
	sequence pos_still;
		($stable(open_pos_i) && $stable(closed_pos_i))[*5];
	endsequence
	sequence clr_done;
		clear_stats_o ##1 (!clear_stats_o && open_ok_cnt_o == 32'h0 && close_fail_cnt_o == 32'h0);
	endsequence
	AST_CMD_EXCL: assert property (!(open_cmd_o && close_cmd_o))
		else $error("both commands high");
	AST_STATUS: assert property (pos_still |-> breaker_status_o == {closed_pos_i, open_pos_i})
		else $error("status wrong");
	AST_CART_OFF: assert property ((object_type_i != 2'h0)[*3] |-> cart_status_o == SOC_CART_NOT_USED)
		else $error("cart monitored");
	AST_EARTH: assert property ((object_type_i == 2'h3)[*3] |-> !open_cmd_o && !close_cmd_o)
		else $error("earth command");
	AST_SYNC: assert property ($rose(close_cmd_o) && object_type_i != 2'h2 && sync_use_i |-> sync_ok_i)
		else $error("close without sync");
	AST_READY: assert property ($rose(close_cmd_o) && object_type_i != 2'h2 && ready_use_i < 2'h2
		|-> ready_i == (ready_use_i == SOC_RDY_HIGH)) else $error("close not ready");
	AST_CLEAR: assert property ($rose(clear_stats_i) |=> clr_done)
		else $error("clear failed");
	AST_PULSE: assert property (hi_cnt <= PULSE_CYC)
		else $error("pulse too long");
	AST_OK_STEP: assert property ($changed(open_ok_cnt_o) && open_ok_cnt_o != 32'h0
		|-> open_ok_cnt_o == $past(open_ok_cnt_o) + 32'h1) else $error("ok count step");
	AST_FAIL_STEP: assert property ($changed(close_fail_cnt_o) && close_fail_cnt_o != 32'h0
		|-> close_fail_cnt_o == $past(close_fail_cnt_o) + 32'h1) else $error("fail count step");
endmodule
bind soc_object_ctrl soc_object_ctrl_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.*);

/* verification/soc_gear_model.sv */
// Purpose: Behavioural switchgear object driving its position contacts
// Assumes: Travel time in cycles on delay_i; 8'hff never arrives
// Notes:   Both contacts drop while travelling, as a real mechanism does
`timescale 1ns/1ns
module soc_gear_model
(
	input  wire logic       sys_clk_i,
	input  wire logic       open_cmd_i,
	input  wire logic       close_cmd_i,
	input  wire logic [7:0] delay_i,
	output logic            open_pos_o,
	output logic            closed_pos_o
);
	logic [7:0] cnt;
	logic       moving, to_close, cmd_q;
	initial
	begin
		open_pos_o = 1'b1;
		closed_pos_o = 1'b0;
		moving = 1'b0;
		cmd_q = 1'b0;
	end
	always @(posedge sys_clk_i)
	begin
		cmd_q <= open_cmd_i || close_cmd_i;
		// Only a fresh pulse starts travel; a lingering one is ignored
		if (!moving && (open_cmd_i || close_cmd_i) && !cmd_q)
		begin
			moving <= 1'b1;
			to_close <= close_cmd_i;
			cnt <= delay_i;
			open_pos_o <= 1'b0;
			closed_pos_o <= 1'b0;
		end
		else if (moving && cnt == 8'h0)
		begin
			moving <= 1'b0;
			open_pos_o <= !to_close;
			closed_pos_o <= to_close;
		end
		else if (moving && delay_i != 8'hff)
			cnt <= (cnt > delay_i) ? delay_i : cnt - 8'h1;
	end
endmodule

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the object control block
// Assumes: Short pulse and timeout parameters
// Notes:   Counter snapshots are queued per request of kind 0 or 1 and per clear
`timescale 1ns/1ns
module tb_top
	import soc_pkg::*;
;
	logic         sys_clk_i, rst_n_i, sync_use_i, open_pos_i, closed_pos_i, ready_i, sync_ok_i, bz, te;
	logic         cart_inserted_input_i, cart_removed_input_i, open_req_i, close_req_i, clear_stats_i;
	logic         open_block_i, close_block_i, open_cmd_o, close_cmd_o, busy_o, clear_stats_o;
	logic         ctrl_error_o, req_refused_o;
	logic [1:0]   object_type_i, ready_use_i, breaker_status_o;
	logic [2:0]   cart_status_o;
	logic [31:0]  open_ok_cnt_o, close_ok_cnt_o, open_fail_cnt_o, close_fail_cnt_o, eo, ec, fc, rs;
	logic [7:0]   dly;
	logic [127:0] notes[$];
	logic [7:0]   tbl[10] = '{8'h28, 8'hba, 8'h3b, 8'ha1, 8'h23, 8'ha7, 8'h25, 8'h9a, 8'h50, 8'h08};
	int           errors, n_checks;
	soc_object_ctrl #(.PULSE_CYC(20), .TOUT_CYC(100)) DUT (.*);
	soc_gear_model u_gear (.sys_clk_i(sys_clk_i), .open_cmd_i(open_cmd_o), .close_cmd_i(close_cmd_o),
		.delay_i(dly), .open_pos_o(open_pos_i), .closed_pos_o(closed_pos_i));
	initial
	begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [7:0] rnd_dly();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return 8'h2 + 8'(rs % 32'd14);
	endfunction
	task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string nm);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cfg(input logic [6:0] c);
		{object_type_i, sync_use_i, ready_use_i, ready_i, sync_ok_i} <= c;
		repeat (4) @(posedge sys_clk_i);
	endtask
	// Kind 0 completes, 1 fails, 2 must be ignored
	task automatic op(input logic c, input logic [7:0] d, input int k);
		int i;
		dly <= d;
		if (k == 0 && c) ec++;
		if (k == 0 && !c) eo++;
		if (k == 1) fc++;
		if (k < 2) notes.push_back({eo, ec, 32'h0, fc});
		open_req_i <= !c;
		close_req_i <= c;
		@(posedge sys_clk_i);
		open_req_i <= 1'b0;
		close_req_i <= 1'b0;
		@(posedge sys_clk_i) #1;
		if (k == 2) chk(open_cmd_o | close_cmd_o, 128'h0, "cmd");
		for (i = 0; i < 300 && busy_o; i++) @(posedge sys_clk_i) #1;
		repeat (4) @(posedge sys_clk_i);
	endtask
	initial
	begin
		bz = 1'b0;
		forever
		begin
			@(posedge sys_clk_i) #1;
			if ((bz && !busy_o) || req_refused_o || clear_stats_o)
			begin
				// Error pulse stands only in the cycle after busy falls
				if (bz && !busy_o)
					chk(ctrl_error_o, te, "error");
				@(posedge sys_clk_i) #1;
				chk({open_ok_cnt_o, close_ok_cnt_o, open_fail_cnt_o, close_fail_cnt_o},
					notes.size() ? notes.pop_front() : 'x, "counters");
			end
			bz = busy_o;
		end
	end
	initial
	begin
		repeat (8000) @(posedge sys_clk_i);
		errors++;
		test_done();
	end
	initial
	begin
		{rs, eo, ec, fc, dly} = {32'd62001, 96'h0, 8'h3};
		{te, rst_n_i, open_req_i, close_req_i, open_block_i, close_block_i, clear_stats_i} = 7'h0;
		{object_type_i, sync_use_i, ready_use_i, ready_i, sync_ok_i} = 7'h28;
		{cart_inserted_input_i, cart_removed_input_i} = 2'h1;
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		for (int j = 0; j < 10; j++)
		begin
			cfg(tbl[j][6:0]);
			op(1'b1, rnd_dly(), int'(tbl[j][7]));
			if (!tbl[j][7]) op(1'b0, rnd_dly(), 0);
		end
		cfg(7'h28);
		op(1'b1, 8'd40, 0);
		open_block_i <= 1'b1;
		op(1'b0, 8'h3, 2);
		open_block_i <= 1'b0;
		op(1'b0, 8'h3, 0);
		cfg(7'h68);
		op(1'b1, 8'h3, 2);
		cfg(7'h28);
		te = 1'b1;
		op(1'b1, 8'hff, 1);
		te = 1'b0;
		dly <= 8'h3;
		repeat (10) @(posedge sys_clk_i);
		op(1'b0, 8'h3, 0);
		{cart_inserted_input_i, cart_removed_input_i} <= 2'h2;
		cfg(7'h08);
		#1 chk(cart_status_o, SOC_CART_IN, "cart");
		{eo, ec, fc} = 96'h0;
		notes.push_back(128'h0);
		@(posedge sys_clk_i) clear_stats_i <= 1'b1;
		@(posedge sys_clk_i) clear_stats_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		test_done();
	end
endmodule
